/* core/mcu_decode_map.svh */
`ifndef MCU_DECODE_MAP_SVH
`define MCU_DECODE_MAP_SVH

`define INSTR_W 14
`define PC_W 13
`define CLASS_HI 13
`define CLASS_LO 12
`define OPC_HI 11
`define OPC_LO 8
`define DEST_BIT 7
`define FADDR_HI 6
`define BSEL_HI 9
`define BSEL_LO 7
`define LIT8_HI 7
`define LIT11_HI 10
`define PAGE_W 2
`define NOP_WORD 14'h0000
`define RESET_PC 13'h0000
`define TIMER_ZERO_ADDR 7'h01
`define SECOND_PORT_ADDR 7'h06
`define CTRL_RET 7'h08
`define CTRL_RETI 7'h09
`define CTRL_SLEEP 7'h63
`define CTRL_WDT 7'h64
`define SP_W 3
`define STACK_DEPTH 8

`endif

/* core/mcu_decode_pkg.sv */
package mcu_decode_pkg;

    // one-hot quarter phases of an instruction cycle
    typedef enum logic [3:0] {
        PH_Q1 = 4'b0001,
        PH_Q2 = 4'b0010,
        PH_Q3 = 4'b0100,
        PH_Q4 = 4'b1000
    } phase_t;

    typedef enum logic [1:0] {
        CLS_BYTE = 2'h0,
        CLS_BIT = 2'h1,
        CLS_LIT = 2'h2
    } instr_class_t;

    typedef enum logic [5:0] {
        OP_NOP, OP_MOV_W_TO_F, OP_CLR_W, OP_CLR_REG, OP_SUB_WF, OP_DEC, OP_OR_WF, OP_AND_WF,
        OP_XOR_WF, OP_ADD_WF, OP_MOV_F, OP_COMP, OP_INC, OP_DEC_SKIP, OP_ROT_R, OP_ROT_L,
        OP_SWAP, OP_INC_SKIP, OP_BIT_CLR, OP_BIT_SET, OP_SKIP_CLR, OP_SKIP_SET, OP_LIT_MOV,
        OP_LIT_RET, OP_LIT_OR, OP_LIT_AND, OP_LIT_XOR, OP_LIT_SUB, OP_LIT_ADD, OP_CALL_SUB,
        OP_JUMP, OP_RET_SUB, OP_RET_INT, OP_STANDBY, OP_WDT_CLR
    } op_t;

endpackage : mcu_decode_pkg

/* core/ret_stack.sv */
`timescale 1ns/100ps
`include "mcu_decode_map.svh"

module ret_stack (
    // clock
    input wire logic clk_in,
    input wire logic ce_in,
    // write side
    input wire logic push_in,
    input wire logic [`SP_W-1:0] wr_addr_in,
    input wire logic [`PC_W-1:0] wr_data_in,
    // read side, data one clock after the address
    input wire logic [`SP_W-1:0] rd_addr_in,
    output logic [`PC_W-1:0] rd_data_out
);
    logic [`PC_W-1:0] mem [`STACK_DEPTH];

    always_ff @(posedge clk_in) begin
        if (ce_in) begin
            if (push_in) begin
                mem[wr_addr_in] <= wr_data_in;
            end
            rd_data_out <= mem[rd_addr_in];
        end
    end
endmodule : ret_stack

/* core/instr_decode.sv */
`timescale 1ns/100ps
`include "mcu_decode_map.svh"

module instr_decode (
    // instruction word
    input wire logic [`INSTR_W-1:0] instr_in,
    // decoded operation and fields
    output mcu_decode_pkg::op_t op_out,
    output mcu_decode_pkg::instr_class_t class_out,
    output logic dest_out,
    output logic [`FADDR_HI:0] faddr_out,
    output logic [`BSEL_HI-`BSEL_LO:0] bsel_out,
    output logic [`LIT8_HI:0] lit8_out,
    output logic [`LIT11_HI:0] lit11_out,
    output logic uses_file_out
);
    import mcu_decode_pkg::*;

    // [RULE14] fixed field positions
    assign dest_out = instr_in[`DEST_BIT];
    assign faddr_out = instr_in[`FADDR_HI:0];
    assign bsel_out = instr_in[`BSEL_HI:`BSEL_LO];
    assign lit8_out = instr_in[`LIT8_HI:0];
    assign lit11_out = instr_in[`LIT11_HI:0];

    // don't-care bits are simply never compared
    always_comb begin
        op_out = OP_NOP;
        class_out = CLS_BYTE;
        // [RULE2] exactly one class
        case (instr_in[`CLASS_HI:`CLASS_LO])
            2'h0: begin
                case (instr_in[`OPC_HI:`OPC_LO])
                    4'h0: begin
                        if (instr_in[`DEST_BIT]) begin
                            op_out = OP_MOV_W_TO_F;
                        end else begin
                            class_out = CLS_LIT;
                            case (instr_in[`FADDR_HI:0])
                                `CTRL_RET: op_out = OP_RET_SUB;
                                `CTRL_RETI: op_out = OP_RET_INT;
                                `CTRL_SLEEP: op_out = OP_STANDBY;
                                `CTRL_WDT: op_out = OP_WDT_CLR;
                                default: class_out = CLS_BYTE;
                            endcase
                        end
                    end
                    4'h1: op_out = instr_in[`DEST_BIT] ? OP_CLR_REG : OP_CLR_W;
                    4'h2: op_out = OP_SUB_WF;
                    4'h3: op_out = OP_DEC;
                    4'h4: op_out = OP_OR_WF;
                    4'h5: op_out = OP_AND_WF;
                    4'h6: op_out = OP_XOR_WF;
                    4'h7: op_out = OP_ADD_WF;
                    4'h8: op_out = OP_MOV_F;
                    4'h9: op_out = OP_COMP;
                    4'ha: op_out = OP_INC;
                    4'hb: op_out = OP_DEC_SKIP;
                    4'hc: op_out = OP_ROT_R;
                    4'hd: op_out = OP_ROT_L;
                    4'he: op_out = OP_SWAP;
                    default: op_out = OP_INC_SKIP;
                endcase
            end
            2'h1: begin
                class_out = CLS_BIT;
                case (instr_in[`OPC_HI:`OPC_HI-1])
                    2'h0: op_out = OP_BIT_CLR;
                    2'h1: op_out = OP_BIT_SET;
                    2'h2: op_out = OP_SKIP_CLR;
                    default: op_out = OP_SKIP_SET;
                endcase
            end
            2'h2: begin
                class_out = CLS_LIT;
                op_out = instr_in[`OPC_HI] ? OP_JUMP : OP_CALL_SUB;
            end
            default: begin
                class_out = CLS_LIT;
                // [RULE11] don't-cares accept both
                casez (instr_in[`OPC_HI:`OPC_LO])
                    4'b00??: op_out = OP_LIT_MOV;
                    4'b01??: op_out = OP_LIT_RET;
                    4'b1000: op_out = OP_LIT_OR;
                    4'b1001: op_out = OP_LIT_AND;
                    4'b1010: op_out = OP_LIT_XOR;
                    4'b110?: op_out = OP_LIT_SUB;
                    4'b111?: op_out = OP_LIT_ADD;
                    default: op_out = OP_NOP;
                endcase
            end
        endcase
    end

    assign uses_file_out = (class_out != CLS_LIT) && (op_out != OP_NOP) && (op_out != OP_CLR_W);
endmodule : instr_decode

/* core/mcu_instruction_decode_exec.sv */
`timescale 1ns/100ps
`include "mcu_decode_map.svh"

// Behaviour
// [RULE1] each instruction is fetched and decoded as one 14-bit word
// [RULE2] every instruction falls in byte, bit or literal/control class
// [RULE3] byte ops: destination 0 writes accumulator, 1 writes the file register
// [RULE4] file address is a 7-bit direct address, 00 to 7F
// [RULE5] bit ops change only the selected bit of the addressed register
// [RULE6] literal is 8 bits for data, 11 bits for jump and call
// [RULE7] one instruction cycle is four clock periods
// [RULE8] true skips and program counter changes add a second, empty cycle
// [RULE9] file operands are read, modified, then stored; read always happens
// [RULE10] clearing a port register still reads it first
// [RULE11] don't-care encoding bits accept either value
// [RULE12] modifying the second port reads pin levels, not the latch
// [RULE13] writing timer zero clears the prescaler when assigned to it
// [RULE14] class in top bits; dest bit 7, address 6..0, bit-select 9..7
// [RULE15] reset returns to fetch state and drops any prefetched word
module mcu_instruction_decode_exec (
    // clock, reset, enable
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    // program memory
    output logic [`PC_W-1:0] prog_addr_out,
    input wire logic [`INSTR_W-1:0] prog_data_in,
    input wire logic [`PAGE_W-1:0] pc_page_in,
    // file register access
    output logic [`FADDR_HI:0] file_addr_out,
    output logic file_rd_out,
    output logic file_wr_out,
    output logic [`LIT8_HI:0] file_wdata_out,
    input wire logic [`LIT8_HI:0] file_rdata_in,
    // second port pins and timer zero prescaler
    input wire logic [`LIT8_HI:0] port_pins_in,
    input wire logic prescaler_to_timer_in,
    output logic prescaler_clear_out,
    // core state
    output logic [`LIT8_HI:0] w_out,
    output logic zero_out,
    output logic carry_out,
    output logic digit_carry_out,
    output mcu_decode_pkg::instr_class_t instr_class_out,
    output logic sleep_out,
    output logic wdt_clear_out,
    output logic int_return_out
);
    import mcu_decode_pkg::*;

    phase_t phase, next_phase;
    logic [`PC_W-1:0] pc, next_pc, target, next_target;
    logic [`INSTR_W-1:0] ir, next_ir;
    logic [`LIT8_HI:0] w, next_w, operand, next_operand, wdata, next_wdata;
    logic z, next_z, c, next_c, dc, next_dc, flush, next_flush;
    logic [`SP_W-1:0] sp, next_sp;
    logic [`FADDR_HI:0] faddr_q, next_faddr_q;
    logic rd_q, next_rd_q, wr_q, next_wr_q, psc_q, next_psc_q;
    logic sleep_q, next_sleep_q, wdt_q, next_wdt_q, reti_q, next_reti_q;
    instr_class_t cls_q, next_cls_q;
    logic [`LIT8_HI:0] pin_s1, pin_s2, pin_s3, pin_stable, next_pin_stable;

    op_t op;
    instr_class_t cls;
    logic dest, uses_file;
    logic [`FADDR_HI:0] faddr;
    logic [`BSEL_HI-`BSEL_LO:0] bsel;
    logic [`LIT8_HI:0] lit8, alu_a, res, bmask;
    logic [`LIT11_HI:0] lit11;
    logic [`PC_W-1:0] stack_top;
    logic [`LIT8_HI+1:0] wide;
    logic r_c, r_dc, upd_z, to_file, to_w, skip, jump, push, pop;

    // [RULE1] decode of the full word
    instr_decode u_decode (
        .instr_in(ir),
        .op_out(op),
        .class_out(cls),
        .dest_out(dest),
        .faddr_out(faddr),
        .bsel_out(bsel),
        .lit8_out(lit8),
        .lit11_out(lit11),
        .uses_file_out(uses_file)
    );

    assign push = ce_in && (phase == PH_Q3) && (op == OP_CALL_SUB);
    ret_stack u_stack (
        .clk_in(clk_in),
        .ce_in(ce_in),
        .push_in(push),
        .wr_addr_in(sp),
        .wr_data_in(pc),
        .rd_addr_in(sp - `SP_W'(1)),
        .rd_data_out(stack_top)
    );

    // pins settle through three flops; a level counts once stages two and three agree
    for (genvar gi = 0; gi <= `LIT8_HI; gi++) begin : g_pin
        assign next_pin_stable[gi] = (pin_s2[gi] == pin_s3[gi]) ? pin_s3[gi] : pin_stable[gi];
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            pin_s1 <= 8'h00;
            pin_s2 <= 8'h00;
            pin_s3 <= 8'h00;
            pin_stable <= 8'h00;
        end else if (ce_in) begin
            pin_s1 <= port_pins_in;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_stable <= next_pin_stable;
        end
    end

    // execution unit; literal ops take the constant in place of the file value
    always_comb begin
        // [RULE6] 8-bit literal for data
        alu_a = (cls == CLS_LIT) ? lit8 : operand;
        res = alu_a;
        r_c = c;
        r_dc = dc;
        upd_z = 1'b0;
        to_file = 1'b0;
        to_w = 1'b0;
        skip = 1'b0;
        jump = 1'b0;
        pop = 1'b0;
        wide = {1'b0, alu_a} + {1'b0, w};
        // [RULE5] one-bit mask
        bmask = 8'h01 << bsel;
        case (op)
            OP_SUB_WF, OP_DEC, OP_OR_WF, OP_AND_WF, OP_XOR_WF, OP_ADD_WF, OP_MOV_F, OP_COMP, OP_INC,
            OP_DEC_SKIP, OP_ROT_R, OP_ROT_L, OP_SWAP, OP_INC_SKIP: begin
                // [RULE3] destination select
                to_file = dest;
                to_w = ~dest;
            end
            OP_BIT_CLR, OP_BIT_SET, OP_MOV_W_TO_F, OP_CLR_REG: to_file = 1'b1;
            OP_CLR_W, OP_LIT_MOV, OP_LIT_RET, OP_LIT_OR, OP_LIT_AND, OP_LIT_XOR, OP_LIT_SUB,
            OP_LIT_ADD: to_w = 1'b1;
            default: to_w = 1'b0;
        endcase
        case (op)
            OP_MOV_W_TO_F: res = w;
            // [RULE10] result is zero; for OP_CLR_REG the read already happened, OP_CLR_W reads nothing
            OP_CLR_W, OP_CLR_REG: begin
                res = 8'h00;
                upd_z = 1'b1;
            end
            OP_ADD_WF, OP_LIT_ADD: begin
                {r_c, res} = wide;
                r_dc = ({1'b0, alu_a[3:0]} + {1'b0, w[3:0]}) > 5'h0f;
                upd_z = 1'b1;
            end
            OP_SUB_WF, OP_LIT_SUB: begin
                wide = {1'b0, alu_a} - {1'b0, w};
                res = wide[`LIT8_HI:0];
                r_c = ~wide[`LIT8_HI+1];
                r_dc = alu_a[3:0] >= w[3:0];
                upd_z = 1'b1;
            end
            OP_DEC, OP_DEC_SKIP, OP_INC, OP_INC_SKIP: begin
                res = (op == OP_DEC || op == OP_DEC_SKIP) ? alu_a - 8'h01 : alu_a + 8'h01;
                upd_z = (op == OP_DEC || op == OP_INC);
                // [RULE8] skip on zero
                skip = (op == OP_DEC_SKIP || op == OP_INC_SKIP) && (res == 8'h00);
            end
            OP_OR_WF, OP_LIT_OR: begin
                res = alu_a | w;
                upd_z = 1'b1;
            end
            OP_AND_WF, OP_LIT_AND: begin
                res = alu_a & w;
                upd_z = 1'b1;
            end
            OP_XOR_WF, OP_LIT_XOR: begin
                res = alu_a ^ w;
                upd_z = 1'b1;
            end
            OP_MOV_F, OP_LIT_MOV: upd_z = (op == OP_MOV_F);
            OP_COMP: begin
                res = ~alu_a;
                upd_z = 1'b1;
            end
            OP_ROT_R: {res, r_c} = {c, alu_a};
            OP_ROT_L: {r_c, res} = {alu_a, c};
            OP_SWAP: res = {alu_a[3:0], alu_a[7:4]};
            // [RULE5] only the selected bit moves
            OP_BIT_CLR: res = alu_a & ~bmask;
            OP_BIT_SET: res = alu_a | bmask;
            OP_SKIP_CLR: skip = (alu_a & bmask) == 8'h00;
            OP_SKIP_SET: skip = (alu_a & bmask) != 8'h00;
            OP_LIT_RET, OP_RET_SUB, OP_RET_INT: begin
                jump = 1'b1;
                pop = 1'b1;
            end
            OP_CALL_SUB, OP_JUMP: jump = 1'b1;
            default: res = alu_a;
        endcase
    end

    // [RULE7] four phases per instruction cycle
    always_comb begin
        next_phase = phase;
        next_pc = pc;
        next_target = target;
        next_ir = ir;
        next_w = w;
        next_operand = operand;
        next_wdata = wdata;
        next_z = z;
        next_c = c;
        next_dc = dc;
        next_flush = flush;
        next_sp = sp;
        next_faddr_q = faddr_q;
        next_rd_q = 1'b0;
        next_wr_q = 1'b0;
        next_psc_q = 1'b0;
        next_sleep_q = 1'b0;
        next_wdt_q = 1'b0;
        next_reti_q = 1'b0;
        next_cls_q = cls;
        case (phase)
            PH_Q1: begin
                next_phase = PH_Q2;
                // [RULE9] read first, even for pure writes
                if (uses_file) begin
                    // [RULE4] 7-bit direct address
                    next_faddr_q = faddr;
                    next_rd_q = 1'b1;
                end
            end
            PH_Q2: begin
                next_phase = PH_Q3;
                // [RULE12] port value comes from the pins
                if (uses_file) begin
                    next_operand = (faddr == `SECOND_PORT_ADDR) ? pin_stable : file_rdata_in;
                end
            end
            PH_Q3: begin
                next_phase = PH_Q4;
                // [RULE9] store as directed
                if (to_file) begin
                    next_wr_q = 1'b1;
                    next_wdata = res;
                    // [RULE13] timer write clears prescaler
                    next_psc_q = (faddr == `TIMER_ZERO_ADDR) && prescaler_to_timer_in;
                end
                if (to_w) begin
                    next_w = res;
                end
                if (upd_z) begin
                    next_z = (res == 8'h00);
                end
                next_c = r_c;
                next_dc = r_dc;
                next_sleep_q = (op == OP_STANDBY);
                next_wdt_q = (op == OP_WDT_CLR);
                next_reti_q = (op == OP_RET_INT);
                // [RULE8] taken branch or skip drops the prefetch
                next_flush = skip || jump;
                // [RULE6] 11-bit target
                next_target = pop ? stack_top : (jump ? {pc_page_in, lit11} : pc + `PC_W'(1));
                if (push) begin
                    next_sp = sp + `SP_W'(1);
                end else if (pop) begin
                    next_sp = sp - `SP_W'(1);
                end
            end
            PH_Q4: begin
                next_phase = PH_Q1;
                next_pc = target;
                // [RULE8] second cycle runs as an empty word
                next_ir = flush ? `NOP_WORD : prog_data_in;
                next_flush = 1'b0;
            end
            default: next_phase = PH_Q1;
        endcase
    end

    always_ff @(posedge clk_in) begin
        // [RULE15] back to fetch, prefetch discarded
        if (reset_in) begin
            phase <= PH_Q1;
            pc <= `RESET_PC;
            target <= `RESET_PC;
            ir <= `NOP_WORD;
            w <= 8'h00;
            operand <= 8'h00;
            wdata <= 8'h00;
            z <= 1'b0;
            c <= 1'b0;
            dc <= 1'b0;
            flush <= 1'b0;
            sp <= `SP_W'(0);
            faddr_q <= (`FADDR_HI+1)'(0);
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            psc_q <= 1'b0;
            sleep_q <= 1'b0;
            wdt_q <= 1'b0;
            reti_q <= 1'b0;
            cls_q <= CLS_BYTE;
        end else if (ce_in) begin
            phase <= next_phase;
            pc <= next_pc;
            target <= next_target;
            ir <= next_ir;
            w <= next_w;
            operand <= next_operand;
            wdata <= next_wdata;
            z <= next_z;
            c <= next_c;
            dc <= next_dc;
            flush <= next_flush;
            sp <= next_sp;
            faddr_q <= next_faddr_q;
            rd_q <= next_rd_q;
            wr_q <= next_wr_q;
            psc_q <= next_psc_q;
            sleep_q <= next_sleep_q;
            wdt_q <= next_wdt_q;
            reti_q <= next_reti_q;
            cls_q <= next_cls_q;
        end
    end

    assign prog_addr_out = pc;
    assign file_addr_out = faddr_q;
    assign file_rd_out = rd_q;
    assign file_wr_out = wr_q;
    assign file_wdata_out = wdata;
    assign prescaler_clear_out = psc_q;
    assign w_out = w;
    assign zero_out = z;
    assign carry_out = c;
    assign digit_carry_out = dc;
    assign instr_class_out = cls_q;
    assign sleep_out = sleep_q;
    assign wdt_clear_out = wdt_q;
    assign int_return_out = reti_q;

    // helper: a read was issued during the current instruction cycle
    logic rd_seen;
    always_ff @(posedge clk_in) begin
        if (reset_in || (ce_in && phase == PH_Q1)) begin
            rd_seen <= 1'b0;
        end else if (rd_q) begin
            rd_seen <= 1'b1;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    phase_step_a: assert property ((ce_in && phase == PH_Q1) |=> ##2 (!ce_in || phase == PH_Q4)) // [RULE7]
        else $error("phase order broken");
    fetch_at_q4_a: assert property ($changed(pc) |-> $past(phase) == PH_Q4) // [RULE7]
        else $error("program address moved outside the last phase");
    read_first_a: assert property (wr_q |-> rd_seen) // [RULE9]
        else $error("file write without preceding read");
    clear_reads_a: assert property ((wr_q && op == OP_CLR_REG) |-> (rd_seen && wdata == 8'h00)) // [RULE10]
        else $error("register clear without read or nonzero data");
    dest_select_a: assert property (wr_q |-> (cls == CLS_BIT || dest)) // [RULE3]
        else $error("file written while destination selects the accumulator");
    bit_only_a: assert property ((wr_q && cls == CLS_BIT) |-> ((wdata ^ operand) & ~bmask) == 8'h00) // [RULE5]
        else $error("bit operation touched other bits");
    addr_field_a: assert property (rd_q |-> faddr_q == ir[`FADDR_HI:0]) // [RULE4]
        else $error("file address not taken from low seven bits");
    flush_nop_a: assert property ((ce_in && phase == PH_Q4 && flush) |=> ir == `NOP_WORD) // [RULE8]
        else $error("prefetched word kept after branch or skip");
    pin_read_a: assert property ((ce_in && phase == PH_Q2 && uses_file && faddr == `SECOND_PORT_ADDR) // [RULE12]
        |=> operand == $past(pin_stable))
        else $error("port operand not taken from pins");
    prescaler_a: assert property (psc_q |-> (wr_q && faddr_q == `TIMER_ZERO_ADDR)) // [RULE13]
        else $error("prescaler cleared without timer write");
    reset_fetch_a: assert property ($fell(reset_in) |-> // [RULE15]
        (phase == PH_Q1 && pc == `RESET_PC && ir == `NOP_WORD))
        else $error("reset did not return to fetch");

    call_seen_c: cover property (ce_in && phase == PH_Q3 && op == OP_CALL_SUB);
    skip_taken_c: cover property (ce_in && phase == PH_Q3 && skip);
    port_clear_c: cover property (wr_q && op == OP_CLR_REG && faddr_q == `SECOND_PORT_ADDR);
    prescaler_c: cover property (psc_q);
endmodule : mcu_instruction_decode_exec

/* verif/testbench.sv */
`timescale 1ns/100ps
`include "mcu_decode_map.svh"

module testbench;
    import mcu_decode_pkg::*;

    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [`INSTR_W-1:0] prog_data = `NOP_WORD;
    logic [`LIT8_HI:0] file_rdata = 8'h00;
    logic [`LIT8_HI:0] pins = 8'ha5;
    logic ce = 1'b1;
    logic stall = 1'b0;
    logic psc_assign = 1'b1;
    logic zero_out, carry_out, digit_carry_out, wdt_clear_out, int_return_out;
    logic [`PC_W-1:0] prog_addr_out;
    logic [`FADDR_HI:0] file_addr_out;
    logic file_rd_out, file_wr_out, prescaler_clear_out, sleep_out;
    logic [`LIT8_HI:0] file_wdata_out, w_out;
    instr_class_t instr_class_out;
    logic [`INSTR_W-1:0] rom [0:31];
    logic [7:0] fmem [0:127];
    logic [6:0] rd_addr [$];
    logic [1:0] rd_cls [$];
    logic [15:0] wr_log [$];
    int rd_cyc [$];
    int cyc = 0;
    int pclr = 0;
    int wdt_n = 0;
    int reti_n = 0;
    int bad_count = 0;
    int n_checks = 0;

    always #20 clk_in = ~clk_in;

    mcu_instruction_decode_exec mcu_instruction_decode_exec_i (
        .clk_in(clk_in), .reset_in(reset_in), .ce_in(ce),
        .prog_addr_out(prog_addr_out), .prog_data_in(prog_data), .pc_page_in(2'h0),
        .file_addr_out(file_addr_out), .file_rd_out(file_rd_out), .file_wr_out(file_wr_out),
        .file_wdata_out(file_wdata_out), .file_rdata_in(file_rdata),
        .port_pins_in(pins), .prescaler_to_timer_in(psc_assign), .prescaler_clear_out(prescaler_clear_out),
        .w_out(w_out), .zero_out(zero_out), .carry_out(carry_out), .digit_carry_out(digit_carry_out),
        .instr_class_out(instr_class_out), .sleep_out(sleep_out), .wdt_clear_out(wdt_clear_out),
        .int_return_out(int_return_out)
    );

    // program memory and file registers answer just after each edge
    always @(posedge clk_in) begin
        #1;
        prog_data = rom[prog_addr_out[4:0]];
        file_rdata = fmem[file_addr_out];
        // stalls hold the enable low on every other clock
        ce = stall ? ~ce : 1'b1;
    end

    always @(posedge clk_in) begin
        cyc++;
        // a frozen strobe is counted only on an enabled edge
        if (ce === 1'b1 && file_rd_out === 1'b1) begin
            rd_addr.push_back(file_addr_out);
            rd_cls.push_back(instr_class_out);
            rd_cyc.push_back(cyc);
        end
        if (ce === 1'b1 && file_wr_out === 1'b1) begin
            fmem[file_addr_out] = file_wdata_out;
            wr_log.push_back({1'b0, file_addr_out, file_wdata_out});
        end
        if (ce === 1'b1 && prescaler_clear_out === 1'b1) pclr++;
        if (ce === 1'b1 && wdt_clear_out === 1'b1) wdt_n++;
        if (ce === 1'b1 && int_return_out === 1'b1) reti_n++;
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish

    // runs the program until the standby pulse, bounded
    task automatic run_program();
        int i;
        for (i = 0; i < 400 && sleep_out !== 1'b1; i++) @(posedge clk_in);
        if (i == 400) begin
            chk("standby pulse", 16'h1, 16'h0);
            tally_and_finish();
        end
        repeat (8) @(posedge clk_in);
    endtask : run_program

    // every file operand is read, with its class, four clocks apart except sixteen across the jump
    task automatic check_reads();
        logic [6:0] ea [6] = '{7'h20, 7'h06, 7'h20, 7'h20, 7'h01, 7'h06};
        logic [1:0] ec [6] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h0, 2'h0};
        int eg [5] = '{4, 4, 4, 16, 4};
        chk("read count", 16'd6, 16'(rd_addr.size()));
        for (int i = 0; i < 6 && i < rd_addr.size(); i++) begin
            chk("read address", {9'h0, ea[i]}, {9'h0, rd_addr[i]});
            chk("class", {14'h0, ec[i]}, {14'h0, rd_cls[i]});
            if (i < 5 && i + 1 < rd_addr.size())
                chk("cycle gap", 16'(eg[i]), 16'(rd_cyc[i+1] - rd_cyc[i]));
        end
    endtask : check_reads

    // written values, destinations and side effects
    task automatic check_writes();
        logic [15:0] ew [5] = '{16'h205a, 16'h0600, 16'h205b, 16'h01c3, 16'h06a5};
        chk("write count", 16'd5, 16'(wr_log.size()));
        for (int i = 0; i < 5 && i < wr_log.size(); i++)
            chk("file write", ew[i], wr_log[i]);
        chk("port from pins", 16'h00a5, {8'h0, fmem[6]});
        chk("prescaler clears", 16'd1, 16'(pclr));
        chk("accumulator", 16'h00c3, {8'h0, w_out});
        chk("flags z c dc", 16'h0001, {13'h0, zero_out, carry_out, digit_carry_out});
        chk("watchdog and return pulses", 16'h0101, {8'(wdt_n), 8'(reti_n)});
    endtask : check_writes

    // reset in mid-run returns to the fetch state
    task automatic mid_reset();
        @(posedge clk_in);
        #1 reset_in = 1'b1;
        repeat (2) @(posedge clk_in);
        #1;
        chk("pc after reset", 16'h0, {3'h0, prog_addr_out});
        chk("w after reset", 16'h0, {8'h0, w_out});
        chk("strobes in reset", 16'h0, {14'h0, file_rd_out, file_wr_out});
        reset_in = 1'b0;
    endtask : mid_reset

    // restart from word 0 with stalls, prescaler not assigned and new pin levels
    task automatic second_run();
        psc_assign = 1'b0;
        pins = 8'h96;
        stall = 1'b1;
        run_program();
        chk("reads with stalls", 16'd12, 16'(rd_addr.size()));
        chk("writes with stalls", 16'd10, 16'(wr_log.size()));
        chk("port from new pins", 16'h0096, {8'h0, fmem[6]});
        chk("prescaler left alone", 16'd1, 16'(pclr));
        chk("accumulator rerun", 16'h00c3, {8'h0, w_out});
        chk("flags rerun", 16'h0001, {13'h0, zero_out, carry_out, digit_carry_out});
        chk("pulses rerun", 16'h0202, {8'(wdt_n), 8'(reti_n)});
    endtask : second_run

    initial begin
        for (int i = 0; i < 32; i++) rom[i] = `NOP_WORD;
        for (int i = 0; i < 128; i++) fmem[i] = 8'h3c;
        // load literal, store, clear port, add to w, set bit, jump
        rom[0] = 14'h305a;
        rom[1] = 14'h00a0;
        rom[2] = 14'h0186;
        rom[3] = 14'h0720;
        rom[4] = 14'h1420;
        rom[5] = 14'h280a;
        rom[6] = 14'h30ff;
        // don't-care bits set, timer write, port self-move, call, standby
        rom[10] = 14'h33c3;
        rom[11] = 14'h0081;
        rom[12] = 14'h0886;
        rom[13] = 14'h2018;
        rom[14] = 14'h0063;
        // subroutine: watchdog clear, return from interrupt
        rom[24] = 14'h0064;
        rom[25] = 14'h0009;
        repeat (12) @(posedge clk_in);
        #1 reset_in = 1'b0;
        run_program();
        check_reads();
        check_writes();
        mid_reset();
        second_run();
        tally_and_finish();
    end
endmodule : testbench
